// ---- rtl/cdc_clock_dist_regs.vh ----
// Register offsets, field positions, reset values and mode codes of the clock distribution setup
`ifndef CDC_CLOCK_DIST_REGS_VH
`define CDC_CLOCK_DIST_REGS_VH

`define CDC_ADDR_IFACE_CLK 6'h01
`define CDC_ADDR_TX_PATH 6'h13
`define CDC_ADDR_CLK_SRC 6'h15
`define CDC_ADDR_AUX_SRC 6'h16
`define CDC_ADDR_STATUS 6'h17

`define CDC_RST_IFACE_CLK 8'h00
`define CDC_RST_TX_PATH 8'h00
`define CDC_RST_CLK_SRC 8'h00
`define CDC_RST_AUX_SRC 8'h00

// interface_clock_setup
`define CDC_MODE_MSB 7
`define CDC_MODE_LSB 5
`define CDC_AUX_CLK_EN_BIT 2
`define CDC_DCLK_INV_BIT 1
// transmit_path_setup
`define CDC_TX_FALL_BIT 5
`define CDC_INTERP_MSB 1
`define CDC_INTERP_LSB 0
// clock_source_setup
`define CDC_PLL_BYPASS_BIT 7
`define CDC_ADC_HALVE_BIT 5
`define CDC_SHARED_BIT 4
`define CDC_DIV5_BIT 3
`define CDC_MULT_MSB 2
`define CDC_MULT_LSB 0
// aux_output_source
`define CDC_AUX_SRC_BIT 5

// Timing mode field codes
`define CDC_TMODE_DEFAULT 3'h0
`define CDC_TMODE_OPTIONAL 3'h1
`define CDC_TMODE_CLONE 3'h2

// Interpolation codes
`define CDC_INTERP_X1 2'h0
`define CDC_INTERP_X2 2'h1
`define CDC_INTERP_X4 2'h2

// Clock mode numbers reported on o_clock_mode
`define CDC_CM_FULL 4'h1
`define CDC_CM_FULL_OPT 4'h2
`define CDC_CM_WIDE 4'h4
`define CDC_CM_WIDE_OPT 4'h5
`define CDC_CM_NARROW 4'h7
`define CDC_CM_NARROW_OPT 4'h8
`define CDC_CM_CLONE 4'ha

`endif

// ---- rtl/cdc_clock_dist.v ----
// Clock distribution configuration, rate selection and interface pin formatter
//
// Notes on behaviour
// - Mode field default 000 gives modes 1/4/7
// - Mode field selects optional modes 2/5/8/10
// - Half duplex: role pin is input, sets direction
// - Mode 1/2 pin functions; 2/5/8 tie references
// - Half duplex/clone: data clock follows direction
// - Converter update rate is tx_ref times multiplier
// - Plain tx data clock: update rate over interpolation
// - Interleaved tx data clock: twice that rate
// - Normal timing: rx clock is rx_ref, maybe halved
// - Alternate timing: rx clock is multiplied tx_ref
// - Aux clock continuous, rx_ref or update rate
// - Aux enable bit gates clock, inverts in full duplex
// - Aux source clear selects buffered reference
// - Data clock invert bit inverts data clock pin
// - Tx latch edge select: rising or falling edge
// - Interpolation field sets one, two or four
// - Bypass bit skips the multiplier
// - Halve bit halves converter clock
// - Shared timing bit picks rx path source
// - Divide-by-five bit divides multiplier output
// - Multiplier code 000..100 gives 1..16 times
// - Aux source set selects buffered multiplier clock in half duplex only
// - Alternate timing drives both paths from multiplier
`timescale 1ns/100ps
`include "cdc_clock_dist_regs.vh"

module cdc_clock_dist (
    input wire i_sys_clk,
    input wire i_arst_n,
    input wire [5:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    output reg [7:0] o_reg_rdata,
    input wire i_duplex_select,
    input wire i_half_duplex_width_select,
    input wire i_tx_clk_tap,
    input wire i_rx_clk_tap,
    input wire i_buffered_rx_ref,
    input wire i_pll_clk_tap,
    input wire i_transmit_frame_marker,
    input wire i_receive_frame_marker,
    input wire i_port_role_pin,
    output reg o_port_role_pin,
    output reg o_port_role_pin_oe,
    output reg o_aux_sync_clock_pin,
    output reg o_aux_sync_clock_pin_oe,
    output reg o_data_clock_pin,
    output reg [3:0] o_clock_mode,
    output reg o_tx_active,
    output reg o_refs_tied,
    output reg o_tx_interleaved,
    output reg o_interp_fault,
    output reg o_tx_latch_falling,
    output reg [1:0] o_interp_rate,
    output reg o_pll_bypass,
    output reg [4:0] o_pll_mult,
    output reg o_divide_by_five_enable,
    output reg o_adc_halve,
    output reg o_rx_from_pll,
    output reg [5:0] o_tx_clk_num,
    output reg [4:0] o_tx_clk_den,
    output reg [4:0] o_rx_clk_num,
    output reg [3:0] o_rx_clk_den
);

    reg [7:0] iface_clk_reg;
    reg [7:0] tx_path_reg;
    reg [7:0] clk_src_reg;
    reg [7:0] aux_src_reg;
    // Tap order: tx clk, rx clk, buffered ref, pll clk, tx frame, rx frame, role pin
    reg [6:0] sync1_reg;
    reg [6:0] sync2_reg;

    wire [2:0] tmode;
    wire aux_en;
    wire dclk_inv;
    wire [1:0] interp_code;
    wire [2:0] mult_code;
    wire s_tx_clk;
    wire s_rx_clk;
    wire s_ref_clk;
    wire s_pll_clk;
    wire s_tx_frame;
    wire s_rx_frame;
    wire s_role;

    reg [3:0] mode_next;
    reg [4:0] mult_next;
    reg [2:0] interp_next;
    reg full_duplex;
    reg interleaved;
    reg tied;

    assign tmode = iface_clk_reg[`CDC_MODE_MSB:`CDC_MODE_LSB];
    assign aux_en = iface_clk_reg[`CDC_AUX_CLK_EN_BIT];
    assign dclk_inv = iface_clk_reg[`CDC_DCLK_INV_BIT];
    assign interp_code = tx_path_reg[`CDC_INTERP_MSB:`CDC_INTERP_LSB];
    assign mult_code = clk_src_reg[`CDC_MULT_MSB:`CDC_MULT_LSB];
    assign s_tx_clk = sync2_reg[0];
    assign s_rx_clk = sync2_reg[1];
    assign s_ref_clk = sync2_reg[2];
    assign s_pll_clk = sync2_reg[3];
    assign s_tx_frame = sync2_reg[4];
    assign s_rx_frame = sync2_reg[5];
    assign s_role = sync2_reg[6];

    // Register writes; status is read only and ignores writes
    always @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            iface_clk_reg <= `CDC_RST_IFACE_CLK;
            tx_path_reg <= `CDC_RST_TX_PATH;
            clk_src_reg <= `CDC_RST_CLK_SRC;
            aux_src_reg <= `CDC_RST_AUX_SRC;
        end
        else if (i_reg_wr)
        begin
            case (i_reg_addr)
                `CDC_ADDR_IFACE_CLK: iface_clk_reg <= i_reg_wdata;
                `CDC_ADDR_TX_PATH: tx_path_reg <= i_reg_wdata;
                `CDC_ADDR_CLK_SRC: clk_src_reg <= i_reg_wdata;
                `CDC_ADDR_AUX_SRC: aux_src_reg <= i_reg_wdata;
                default: iface_clk_reg <= iface_clk_reg;
            endcase
        end
    end

    always @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_reg_rdata <= 8'h00;
        else
        begin
            case (i_reg_addr)
                `CDC_ADDR_IFACE_CLK: o_reg_rdata <= iface_clk_reg;
                `CDC_ADDR_TX_PATH: o_reg_rdata <= tx_path_reg;
                `CDC_ADDR_CLK_SRC: o_reg_rdata <= clk_src_reg;
                `CDC_ADDR_AUX_SRC: o_reg_rdata <= aux_src_reg;
                `CDC_ADDR_STATUS: o_reg_rdata <= {o_interp_fault, o_tx_active,
                    o_tx_interleaved, o_refs_tied, o_clock_mode};
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // Pin taps come from other clocks; sampling at 125 MHz only suits slow
    // references, fast taps alias and are a visibility aid, not a clock path
    always @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
        end
        else
        begin
            sync1_reg <= {i_port_role_pin, i_receive_frame_marker, i_transmit_frame_marker,
                i_pll_clk_tap, i_buffered_rx_ref, i_rx_clk_tap, i_tx_clk_tap};
            sync2_reg <= sync1_reg;
        end
    end

    // Clock mode decode; unused field codes fall back to the default mode
    always @*
    begin
        full_duplex = i_duplex_select;
        mode_next = `CDC_CM_FULL;
        if (full_duplex)
        begin
            if (tmode == `CDC_TMODE_OPTIONAL)
                mode_next = `CDC_CM_FULL_OPT;
            else
                mode_next = `CDC_CM_FULL;
        end
        else if (tmode == `CDC_TMODE_CLONE)
            mode_next = `CDC_CM_CLONE;
        else if (i_half_duplex_width_select)
            mode_next = (tmode == `CDC_TMODE_OPTIONAL) ? `CDC_CM_NARROW_OPT : `CDC_CM_NARROW;
        else
            mode_next = (tmode == `CDC_TMODE_OPTIONAL) ? `CDC_CM_WIDE_OPT : `CDC_CM_WIDE;
        tied = (mode_next == `CDC_CM_FULL_OPT) || (mode_next == `CDC_CM_WIDE_OPT) ||
            (mode_next == `CDC_CM_NARROW_OPT);
        interleaved = (mode_next == `CDC_CM_FULL) || (mode_next == `CDC_CM_FULL_OPT) ||
            (mode_next == `CDC_CM_NARROW) || (mode_next == `CDC_CM_NARROW_OPT) ||
            (mode_next == `CDC_CM_CLONE);
    end

    // Multiplier and interpolation factors
    always @*
    begin
        mult_next = 5'h01;
        if (!clk_src_reg[`CDC_PLL_BYPASS_BIT])
        begin
            case (mult_code)
                3'h0: mult_next = 5'h01;
                3'h1: mult_next = 5'h02;
                3'h2: mult_next = 5'h04;
                3'h3: mult_next = 5'h08;
                3'h4: mult_next = 5'h10;
                default: mult_next = 5'h01;
            endcase
        end
        case (interp_code)
            `CDC_INTERP_X2: interp_next = 3'h2;
            `CDC_INTERP_X4: interp_next = 3'h4;
            default: interp_next = 3'h1;
        endcase
    end

    // Rate ratios, each relative to its reference input
    always @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_clock_mode <= `CDC_CM_FULL;
            o_refs_tied <= 1'b0;
            o_tx_interleaved <= 1'b0;
            o_interp_fault <= 1'b0;
            o_tx_latch_falling <= 1'b0;
            o_interp_rate <= 2'h0;
            o_pll_bypass <= 1'b0;
            o_pll_mult <= 5'h01;
            o_divide_by_five_enable <= 1'b0;
            o_adc_halve <= 1'b0;
            o_rx_from_pll <= 1'b0;
            o_tx_clk_num <= 6'h01;
            o_tx_clk_den <= 5'h01;
            o_rx_clk_num <= 5'h01;
            o_rx_clk_den <= 4'h1;
        end
        else
        begin
            o_clock_mode <= mode_next;
            o_refs_tied <= tied;
            o_tx_interleaved <= interleaved;
            // Interleaved data without interpolation is a setup error by software
            o_interp_fault <= interleaved && (interp_next == 3'h1);
            o_tx_latch_falling <= tx_path_reg[`CDC_TX_FALL_BIT];
            o_interp_rate <= interp_code;
            o_pll_bypass <= clk_src_reg[`CDC_PLL_BYPASS_BIT];
            o_pll_mult <= mult_next;
            o_divide_by_five_enable <= clk_src_reg[`CDC_DIV5_BIT];
            o_adc_halve <= clk_src_reg[`CDC_ADC_HALVE_BIT];
            o_rx_from_pll <= clk_src_reg[`CDC_SHARED_BIT];
            o_tx_clk_num <= interleaved ? {mult_next, 1'b0} : {1'b0, mult_next};
            o_tx_clk_den <= clk_src_reg[`CDC_DIV5_BIT] ? (interp_next * 5'h05) :
                {2'h0, interp_next};
            if (clk_src_reg[`CDC_SHARED_BIT])
            begin
                o_rx_clk_num <= mult_next;
                o_rx_clk_den <= (clk_src_reg[`CDC_DIV5_BIT] ? 4'h5 : 4'h1) <<
                    clk_src_reg[`CDC_ADC_HALVE_BIT];
            end
            else
            begin
                o_rx_clk_num <= 5'h01;
                o_rx_clk_den <= clk_src_reg[`CDC_ADC_HALVE_BIT] ? 4'h2 : 4'h1;
            end
        end
    end

    // Output clock formatter for the three interface pins
    always @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_port_role_pin <= 1'b0;
            o_port_role_pin_oe <= 1'b0;
            o_aux_sync_clock_pin <= 1'b0;
            o_aux_sync_clock_pin_oe <= 1'b0;
            o_data_clock_pin <= 1'b0;
            o_tx_active <= 1'b0;
        end
        else if (full_duplex)
        begin
            o_port_role_pin <= s_tx_frame;
            o_port_role_pin_oe <= 1'b1;
            o_tx_active <= 1'b1;
            // Aux pin always drives in full duplex; the enable bit inverts it
            o_aux_sync_clock_pin_oe <= 1'b1;
            if (mode_next == `CDC_CM_FULL_OPT)
                o_aux_sync_clock_pin <= s_rx_frame ^ aux_en;
            else
                o_aux_sync_clock_pin <= s_ref_clk ^ aux_en;
            o_data_clock_pin <= s_tx_clk ^ dclk_inv;
        end
        else
        begin
            // Role pin is released so the back end can drive it
            o_port_role_pin <= 1'b0;
            o_port_role_pin_oe <= 1'b0;
            o_tx_active <= s_role;
            o_aux_sync_clock_pin_oe <= aux_en;
            if (!aux_en)
                o_aux_sync_clock_pin <= 1'b0;
            else if (aux_src_reg[`CDC_AUX_SRC_BIT])
                o_aux_sync_clock_pin <= s_pll_clk;
            else
                o_aux_sync_clock_pin <= s_ref_clk;
            o_data_clock_pin <= (s_role ? s_tx_clk : s_rx_clk) ^ dclk_inv;
        end
    end

endmodule // cdc_clock_dist

// ---- tb/cdc_clock_dist_asserts.sv ----
// Concurrent checks on the clock distribution setup block
`timescale 1ns/100ps
module cdc_clock_dist_asserts (
    input wire i_sys_clk,
    input wire i_arst_n,
    input wire [5:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire o_port_role_pin_oe,
    input wire [3:0] o_clock_mode,
    input wire o_refs_tied,
    input wire o_tx_interleaved,
    input wire o_interp_fault,
    input wire [1:0] o_interp_rate,
    input wire [4:0] o_pll_mult,
    input wire o_divide_by_five_enable,
    input wire o_adc_halve,
    input wire o_rx_from_pll,
    input wire [5:0] o_tx_clk_num,
    input wire [4:0] o_tx_clk_den,
    input wire [4:0] o_rx_clk_num,
    input wire [3:0] o_rx_clk_den
);
    wire [3:0] m = o_clock_mode;
    wire tied = (m == 4'h2) | (m == 4'h5) | (m == 4'h8);
    wire ilv = (m == 4'h1) | (m == 4'h2) | (m == 4'h7) | (m == 4'h8) | (m == 4'ha);
    // Code 11 falls back to 1x, so only 01 and 10 raise the rate
    wire [4:0] ir = (o_interp_rate == 2'h1) ? 5'h2 : (o_interp_rate == 2'h2) ? 5'h4 : 5'h1;
    wire [3:0] d5 = o_divide_by_five_enable ? 4'h5 : 4'h1;
    wire [3:0] h2 = o_adc_halve ? 4'h2 : 4'h1;
    wire w15 = i_reg_wr & (i_reg_addr == 6'h15);
    // Reset values of mode and derived flags disagree until the first edge after release
    reg [1:0] settle_reg;
    always @(posedge i_sys_clk or negedge i_arst_n)
        if (!i_arst_n)
            settle_reg <= 2'h0;
        else if (settle_reg != 2'h3)
            settle_reg <= settle_reg + 2'h1;
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n || settle_reg != 2'h3);
    chk_tied_modes: assert property (o_refs_tied == tied)
        else $error("tied flag wrong");
    chk_ilv_modes: assert property (o_tx_interleaved == ilv)
        else $error("interleave flag wrong");
    chk_fault_flag: assert property (o_interp_fault == (ilv && ir == 5'h1))
        else $error("fault flag wrong");
    chk_role_input: assert property (m > 4'h2 |-> !o_port_role_pin_oe)
        else $error("role pin driven in half duplex");
    chk_mult_code: assert property (w15 && !i_reg_wdata[7]
        && i_reg_wdata[2:0] < 3'h5 |-> ##2 o_pll_mult == 5'h1 << $past(i_reg_wdata[2:0], 2))
        else $error("multiplier decode wrong");
    chk_cfg_hold: assert property ((!i_reg_wr) [*2] |=>
        $stable(o_pll_mult) && $stable(o_rx_from_pll))
        else $error("clock setup moved without a write");
    chk_tx_num: assert property (o_tx_clk_num == {1'b0, o_pll_mult} << o_tx_interleaved)
        else $error("tx clock numerator wrong");
    chk_tx_den: assert property (o_tx_clk_den == ir * d5)
        else $error("tx clock denominator wrong");
    chk_rx_norm: assert property (!o_rx_from_pll |->
        o_rx_clk_num == 5'h1 && o_rx_clk_den == h2)
        else $error("normal rx ratio wrong");
    chk_rx_alt: assert property (o_rx_from_pll |->
        o_rx_clk_num == o_pll_mult && o_rx_clk_den == d5 * h2)
        else $error("alternate rx ratio wrong");
endmodule // cdc_clock_dist_asserts

bind cdc_clock_dist cdc_clock_dist_asserts i_chk (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .o_port_role_pin_oe(o_port_role_pin_oe), .o_clock_mode(o_clock_mode),
    .o_refs_tied(o_refs_tied), .o_tx_interleaved(o_tx_interleaved),
    .o_interp_fault(o_interp_fault), .o_interp_rate(o_interp_rate), .o_pll_mult(o_pll_mult),
    .o_divide_by_five_enable(o_divide_by_five_enable), .o_adc_halve(o_adc_halve), .o_rx_from_pll(o_rx_from_pll),
    .o_tx_clk_num(o_tx_clk_num), .o_tx_clk_den(o_tx_clk_den),
    .o_rx_clk_num(o_rx_clk_num), .o_rx_clk_den(o_rx_clk_den));

// ---- tb/cdc_backend.sv ----
// Back end model: role pin in half duplex and the frame markers
`timescale 1ns/100ps
module cdc_backend (
    input wire i_clk,
    input wire i_dev_oe,
    input wire i_tx_want,
    input wire i_mark,
    output wire o_role,
    output wire o_tx_mark,
    output wire o_rx_mark
);
    reg last_reg = 1'b0;
    always @(posedge i_clk)
        last_reg <= o_role;
    // While the device drives the pin this side is unused; it toggles so a bad mux shows
    assign o_role = i_dev_oe ? ~last_reg : i_tx_want;
    assign o_tx_mark = i_mark;
    assign o_rx_mark = ~i_mark;
endmodule // cdc_backend

// ---- tb/cdc_clock_dist_bench.sv ----
// Self-checking bench for the clock distribution setup block
`timescale 1ns/100ps
`include "cdc_clock_dist_regs.vh"
module cdc_clock_dist_bench;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [5:0] addr = 6'h0;
    reg [7:0] wdata = 8'h0;
    reg wr = 1'b0;
    reg dup = 1'b1;
    reg narrow = 1'b0;
    reg [3:0] taps = 4'h0;
    reg tx_want = 1'b0;
    reg mark = 1'b0;
    wire be_role, tx_mark, rx_mark, role_out, role_oe, aux, aux_oe, dclk, tx_act, fall, rx_pll;
    wire [7:0] rdata;
    wire [3:0] mode;
    wire [4:0] mult;
    wire [1:0] irate;
    wire byp;
    wire role = role_oe ? role_out : be_role;
    integer fail_count = 0;
    integer comparisons = 0;
    always #4 clk = ~clk;
    cdc_backend i_cdc_backend (.i_clk(clk), .i_dev_oe(role_oe), .i_tx_want(tx_want),
        .i_mark(mark), .o_role(be_role), .o_tx_mark(tx_mark), .o_rx_mark(rx_mark));
    cdc_clock_dist i_cdc_clock_dist (.i_sys_clk(clk), .i_arst_n(rst_n), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .o_reg_rdata(rdata), .i_duplex_select(dup),
        .i_half_duplex_width_select(narrow), .i_tx_clk_tap(taps[0]), .i_rx_clk_tap(taps[1]),
        .i_buffered_rx_ref(taps[2]), .i_pll_clk_tap(taps[3]), .i_transmit_frame_marker(tx_mark),
        .i_receive_frame_marker(rx_mark), .i_port_role_pin(role), .o_port_role_pin(role_out),
        .o_port_role_pin_oe(role_oe), .o_aux_sync_clock_pin(aux), .o_aux_sync_clock_pin_oe(aux_oe),
        .o_data_clock_pin(dclk), .o_clock_mode(mode), .o_tx_active(tx_act), .o_refs_tied(),
        .o_tx_interleaved(), .o_interp_fault(), .o_tx_latch_falling(fall), .o_interp_rate(irate),
        .o_pll_bypass(byp), .o_pll_mult(mult), .o_divide_by_five_enable(), .o_adc_halve(),
        .o_rx_from_pll(rx_pll), .o_tx_clk_num(), .o_tx_clk_den(), .o_rx_clk_num(),
        .o_rx_clk_den());
    task cmp(input [7:0] got, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp)
            begin
                fail_count = fail_count + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
        end
    endtask
    task wreg(input [5:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            tick(3);
        end
    endtask
    task rchk(input [5:0] a, input [7:0] e);
        begin
            @(posedge clk);
            addr <= a;
            tick(2);
            cmp(rdata, e);
        end
    endtask
    // ds/as pick the tap expected on the data clock and aux pins; as of 4 means aux off
    task pins(input [1:0] ds, input [2:0] as, input di, input ai);
        integer k;
        reg [3:0] p;
        begin
            for (k = 0; k < 3; k = k + 1)
            begin
                p = 4'h3 << k;
                @(posedge clk);
                taps <= p;
                tick(5);
                cmp({6'h0, dclk, aux}, {6'h0, p[ds] ^ di, (as < 3'h4) & (p[as[1:0]] ^ ai)});
                cmp({7'h0, aux_oe}, {7'h0, as < 3'h4});
            end
        end
    endtask
    task t_reset;
        begin
            rchk(`CDC_ADDR_IFACE_CLK, 8'h00);
            rchk(`CDC_ADDR_TX_PATH, 8'h00);
            rchk(`CDC_ADDR_CLK_SRC, 8'h00);
            rchk(`CDC_ADDR_AUX_SRC, 8'h00);
            rchk(`CDC_ADDR_STATUS, 8'he1);
            wreg(`CDC_ADDR_STATUS, 8'h00);
            wreg(6'h20, 8'hff);
            rchk(6'h20, 8'h00);
            rchk(`CDC_ADDR_STATUS, 8'he1);
        end
    endtask
    task t_modes;
        integer k;
        reg [15:0] e;
        reg [127:0] tab;
        begin
            tab = 128'h1001_1012_1021_0004_0015_0107_0118_002a;
            for (k = 0; k < 8; k = k + 1)
            begin
                e = tab[k*16 +: 16];
                @(posedge clk);
                dup <= e[12];
                narrow <= e[8];
                wreg(`CDC_ADDR_IFACE_CLK, {e[6:4], 5'h0});
                cmp({4'h0, mode}, {4'h0, e[3:0]});
            end
        end
    endtask
    task t_clocks;
        integer k;
        begin
            for (k = 0; k < 5; k = k + 1)
            begin
                wreg(`CDC_ADDR_CLK_SRC, 8'h10 | k[7:0]);
                cmp({2'h0, byp, mult}, 8'h1 << k);
                cmp({7'h0, rx_pll}, 8'h1);
            end
            wreg(`CDC_ADDR_CLK_SRC, 8'hac);
            cmp({2'h0, byp, mult}, 8'h21);
            cmp({7'h0, rx_pll}, 8'h0);
            rchk(`CDC_ADDR_CLK_SRC, 8'hac);
            wreg(`CDC_ADDR_CLK_SRC, 8'h3b);
            cmp({2'h0, byp, mult}, 8'h08);
            cmp({7'h0, rx_pll}, 8'h1);
        end
    endtask
    task t_interp;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1)
            begin
                wreg(`CDC_ADDR_TX_PATH, {2'h0, k[0], 3'h0, k[1:0]});
                cmp({5'h0, fall, irate}, {5'h0, k[0], k[1:0]});
            end
            wreg(`CDC_ADDR_TX_PATH, 8'h02);
            rchk(`CDC_ADDR_STATUS, 8'h61);
        end
    endtask
    task t_fd_pins;
        begin
            @(posedge clk);
            dup <= 1'b1;
            mark <= 1'b1;
            wreg(`CDC_ADDR_IFACE_CLK, 8'h02);
            pins(2'h0, 3'h2, 1'b1, 1'b0);
            cmp({6'h0, role_oe, role_out}, 8'h03);
            wreg(`CDC_ADDR_IFACE_CLK, 8'h04);
            pins(2'h0, 3'h2, 1'b0, 1'b1);
            wreg(`CDC_ADDR_IFACE_CLK, 8'h24);
            cmp({6'h0, aux, role_out}, 8'h03);
            mark <= 1'b0;
            tick(4);
            cmp({6'h0, aux, role_out}, 8'h00);
        end
    endtask
    task t_hd_pins;
        begin
            @(posedge clk);
            dup <= 1'b0;
            tx_want <= 1'b1;
            wreg(`CDC_ADDR_IFACE_CLK, 8'h00);
            pins(2'h0, 3'h4, 1'b0, 1'b0);
            cmp({6'h0, role_oe, tx_act}, 8'h01);
            tx_want <= 1'b0;
            pins(2'h1, 3'h4, 1'b0, 1'b0);
            cmp({6'h0, role_oe, tx_act}, 8'h00);
            wreg(`CDC_ADDR_IFACE_CLK, 8'h06);
            pins(2'h1, 3'h2, 1'b1, 1'b0);
            wreg(`CDC_ADDR_AUX_SRC, 8'h20);
            pins(2'h1, 3'h3, 1'b1, 1'b0);
        end
    endtask
    task wrap_up;
        begin
            if (fail_count == 0 && comparisons > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial
    begin
        tick(3);
        rst_n <= 1'b1;
        t_reset;
        t_modes;
        t_clocks;
        t_interp;
        t_fd_pins;
        t_hd_pins;
        wrap_up;
    end
    initial
    begin
        tick(20000);
        fail_count = fail_count + 1;
        wrap_up;
    end
endmodule // cdc_clock_dist_bench
